//--- inc/uar_regs.svh
// Constants for the asynchronous UART receive block
`ifndef UAR_REGS_SVH
`define UAR_REGS_SVH

// Receive clock is sixteen times the bit rate
`define UAR_OVERSAMPLE 5'h10
`define UAR_CNT_W 4
// Start-bit centre: falling receive-clock edge after count seven
`define UAR_START_MID 4'h7
// Later bit centres: falling edge after the count wraps to zero
`define UAR_BIT_MID 4'h0
`define UAR_CNT_ZERO 4'h0
`define UAR_CNT_ONE 4'h1

// Character length select codes {hi, lo}
`define UAR_LEN5 2'h0
`define UAR_LEN6 2'h1
`define UAR_LEN7 2'h2
`define UAR_LEN8 2'h3
// Index of the last data bit for each length
`define UAR_LAST5 3'h4
`define UAR_LAST6 3'h5
`define UAR_LAST7 3'h6
`define UAR_LAST8 3'h7
`define UAR_BIT_ONE 3'h1

// Holding register and FIFO entry layout
`define UAR_DATA_W 8
`define UAR_DATA_ZERO 8'h00
`define UAR_ENTRY_W 10
`define UAR_ENTRY_PE 8
`define UAR_ENTRY_FE 9
`define UAR_FIFO_DEPTH 8

// Control latch contents after reset: 5 bits, odd parity, 1 stop
`define UAR_CFG_RST 5'h00

`endif

//--- inc/uar_pkg.sv
// Types shared by the UART receive block
package uar_pkg;

   // Receiver sequencer, one-hot
   typedef enum logic [5:0] {
      UAR_HUNT  = 6'h01,
      UAR_START = 6'h02,
      UAR_DATA  = 6'h04,
      UAR_PAR   = 6'h08,
      UAR_STOP  = 6'h10,
      UAR_WAIT  = 6'h20
   } uar_state_t;

   // Control latch contents
   typedef struct packed {
      logic [1:0] lenSel;
      logic parityOff;
      logic evenPar;
      logic twoStop;
   } uar_cfg_t;

endpackage

//--- inc/uar_fifo_if.sv
// Valid/ready carrier between the receiver and its character FIFO
`timescale 1ns/10ps
interface uar_fifo_if #(parameter int WIDTH = 10);
   logic [WIDTH-1:0] wrData;
   logic wrValid;
   logic wrReady;
   logic [WIDTH-1:0] rdData;
   logic rdValid;
   logic rdReady;

   modport fifo (input wrData, wrValid, rdReady,
                 output wrReady, rdData, rdValid);
   modport user (output wrData, wrValid, rdReady,
                 input wrReady, rdData, rdValid);
endinterface // uar_fifo_if

//--- rtl/uar_fifo.sv
// Synchronous FIFO of received characters with their error bits
`timescale 1ns/10ps
module uar_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 8
) (
   input wire logic clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   uar_fifo_if.fifo bus // Fill and drain sides
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
   logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
   logic [AW:0] count_ff, nxt_count;
   logic push, pop;

   // Full and empty come straight from the occupancy count
   assign bus.wrReady = (count_ff != (AW+1)'(DEPTH));
   assign bus.rdValid = (count_ff != '0);
   assign bus.rdData = mem[rdPtr_ff];
   assign push = bus.wrValid && bus.wrReady;
   assign pop = bus.rdValid && bus.rdReady;

   // Pointer and count updates
   always_comb begin
      nxt_wrPtr = push ? AW'(wrPtr_ff + 1'b1) : wrPtr_ff;
      nxt_rdPtr = pop ? AW'(rdPtr_ff + 1'b1) : rdPtr_ff;
      nxt_count = count_ff;
      if (push && !pop) begin
         nxt_count = (AW+1)'(count_ff + 1'b1);
      end else if (pop && !push) begin
         nxt_count = (AW+1)'(count_ff - 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
      end else begin
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         count_ff <= nxt_count;
      end
   end

   // Storage needs no reset; count guards stale words
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wrPtr_ff] <= bus.wrData;
      end
   end
endmodule // uar_fifo

//--- rtl/uar_rx.sv
// Receive half of an asynchronous serial UART
`timescale 1ns/10ps
`include "uar_regs.svh"
module uar_rx import uar_pkg::*; (
   input wire logic clk, // System clock, 25 MHz
   input wire logic rst, // Master reset, synchronous, active high
   input wire logic rx_line_in, // Serial receive line, idles high
   input wire logic rx_clock_16x, // Receive clock, sixteen times bit rate
   input wire logic clear_char_ready_n, // Clears ready while low
   input wire logic char_len_sel_lo, // Character length select, low bit
   input wire logic char_len_sel_hi, // Character length select, high bit
   input wire logic parity_disable_in, // High: no parity bit, no check
   input wire logic even_parity_sel, // High even, low odd parity
   input wire logic stop_count_sel, // Stop bit count select
   input wire logic control_latch_load, // Latch is open while high
   input wire logic rx_out_float, // High floats the holding outputs
   output logic [7:0] rx_holding_reg, // Received character
   output logic rx_holding_oe, // Drive enable for rx_holding_reg
   output logic char_ready_flag, // A character is waiting
   output logic overrun_flag, // Character landed over an unread one
   output logic parity_fault_flag, // Parity disagreed
   output logic framing_fault_flag // First stop bit was low
);

   // Decode the length select into the index of the last data bit
   function automatic logic [2:0] lastBit(input logic [1:0] sel);
      logic [2:0] idx;
      idx = `UAR_LAST8;
      unique case (sel)
         `UAR_LEN5: idx = `UAR_LAST5;
         `UAR_LEN6: idx = `UAR_LAST6;
         `UAR_LEN7: idx = `UAR_LAST7;
         `UAR_LEN8: idx = `UAR_LAST8;
      endcase
      return idx;
   endfunction

   uar_fifo_if #(.WIDTH(`UAR_ENTRY_W)) chq ();

   uar_fifo #(
      .WIDTH(`UAR_ENTRY_W),
      .DEPTH(`UAR_FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .bus(chq.fifo)
   );

   // Control latch
   uar_cfg_t cfg_ff, nxt_cfg;

   // Receive-clock edge finder
   logic rxClkPrev_ff, nxt_rxClkPrev;
   logic rxRise, rxFall;

   // Receiver sequencer
   uar_state_t state_ff, nxt_state;
   logic [`UAR_CNT_W-1:0] cnt_ff, nxt_cnt;
   logic [2:0] bitIdx_ff, nxt_bitIdx;
   logic [7:0] shift_ff, nxt_shift;
   logic parErr_ff, nxt_parErr;
   logic pushValid_ff, nxt_pushValid;
   logic [`UAR_ENTRY_W-1:0] pushData_ff, nxt_pushData;

   // Holding register and flags
   logic [7:0] hold_ff, nxt_hold;
   logic holdOe_ff, nxt_holdOe;
   logic pend_ff, nxt_pend;
   logic pendFe_ff, nxt_pendFe;
   logic ready_ff, nxt_ready;
   logic clrSeen_ff, nxt_clrSeen;
   logic overrun_ff, nxt_overrun;
   logic parity_ff, nxt_parity;
   logic framing_ff, nxt_framing;
   logic pop, readyNow;

   // Level-loaded latch, following the inputs while load is high
   always_comb begin
      nxt_cfg = cfg_ff;
      if (control_latch_load) begin
         nxt_cfg.lenSel = {char_len_sel_hi, char_len_sel_lo};
         nxt_cfg.parityOff = parity_disable_in;
         nxt_cfg.evenPar = even_parity_sel;
         nxt_cfg.twoStop = stop_count_sel;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg_ff <= `UAR_CFG_RST;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // The receive clock is far slower than clk, so edges are events here
   assign nxt_rxClkPrev = rx_clock_16x;
   assign rxRise = rx_clock_16x && !rxClkPrev_ff;
   assign rxFall = !rx_clock_16x && rxClkPrev_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         rxClkPrev_ff <= 1'b0;
      end else begin
         rxClkPrev_ff <= nxt_rxClkPrev;
      end
   end

   // Receiver sequencer: counts rises, samples on falls at bit centres
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_bitIdx = bitIdx_ff;
      nxt_shift = shift_ff;
      nxt_parErr = parErr_ff;
      nxt_pushData = pushData_ff;
      // An entry waits here until the FIFO takes it
      nxt_pushValid = pushValid_ff && !chq.wrReady;
      if (rxRise && state_ff != UAR_HUNT) begin
         nxt_cnt = `UAR_CNT_W'(cnt_ff + `UAR_CNT_ONE);
      end
      unique case (state_ff)
         UAR_HUNT: begin
            // A full queue holds off the hunt so nothing is dropped
            if (rxRise && !rx_line_in && !pushValid_ff) begin
               nxt_state = UAR_START;
               nxt_cnt = `UAR_CNT_ZERO;
               nxt_shift = `UAR_DATA_ZERO;
               nxt_parErr = 1'b0;
            end
         end
         UAR_START: begin
            if (rxFall && cnt_ff == `UAR_START_MID) begin
               nxt_cnt = `UAR_CNT_ZERO;
               nxt_bitIdx = '0;
               // Glitch on an idle line: go back to hunting
               nxt_state = rx_line_in ? UAR_HUNT : UAR_DATA;
            end
         end
         UAR_DATA: begin
            if (rxFall && cnt_ff == `UAR_BIT_MID) begin
               nxt_shift[bitIdx_ff] = rx_line_in;
               if (bitIdx_ff == lastBit(cfg_ff.lenSel)) begin
                  nxt_state = cfg_ff.parityOff ? UAR_STOP : UAR_PAR;
               end else begin
                  nxt_bitIdx = 3'(bitIdx_ff + `UAR_BIT_ONE);
               end
            end
         end
         UAR_PAR: begin
            if (rxFall && cnt_ff == `UAR_BIT_MID) begin
               // Even: ones plus parity must be even; odd: must be odd
               nxt_parErr = (^shift_ff) ^ rx_line_in ^
                            !cfg_ff.evenPar;
               nxt_state = UAR_STOP;
            end
         end
         UAR_STOP: begin
            if (rxFall && cnt_ff == `UAR_BIT_MID) begin
               nxt_pushData = {!rx_line_in, parErr_ff, shift_ff};
               nxt_pushValid = 1'b1;
               // Second stop bit is not checked; hunting starts here
               nxt_state = rx_line_in ? UAR_HUNT : UAR_WAIT;
            end
         end
         UAR_WAIT: begin
            // Bad stop bit: wait for the line to return high first
            if (rxRise && rx_line_in) begin
               nxt_state = UAR_HUNT;
            end
         end
         default: begin
            nxt_state = UAR_HUNT;
         end
      endcase
   end

   assign chq.wrData = pushData_ff;
   assign chq.wrValid = pushValid_ff;

   always_ff @(posedge clk) begin
      if (rst) begin
         state_ff <= UAR_HUNT;
         cnt_ff <= `UAR_CNT_ZERO;
         bitIdx_ff <= '0;
         shift_ff <= `UAR_DATA_ZERO;
         parErr_ff <= 1'b0;
         pushValid_ff <= 1'b0;
         pushData_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         bitIdx_ff <= nxt_bitIdx;
         shift_ff <= nxt_shift;
         parErr_ff <= nxt_parErr;
         pushValid_ff <= nxt_pushValid;
         pushData_ff <= nxt_pushData;
      end
   end

   // Drain stalls while outputs float or a transfer awaits its half clock
   assign chq.rdReady = !pend_ff && !rx_out_float;
   assign pop = chq.rdValid && chq.rdReady;
   // Ready as seen by this cycle's transfer, honouring a clear in progress
   assign readyNow = ready_ff && clear_char_ready_n;

   // Holding register transfer and status flags
   always_comb begin
      nxt_hold = hold_ff;
      nxt_holdOe = !rx_out_float;
      nxt_pend = pend_ff;
      nxt_pendFe = pendFe_ff;
      nxt_ready = ready_ff;
      nxt_clrSeen = clrSeen_ff;
      nxt_overrun = overrun_ff;
      nxt_parity = parity_ff;
      nxt_framing = framing_ff;
      if (!clear_char_ready_n) begin
         nxt_ready = 1'b0;
         nxt_clrSeen = 1'b1;
      end
      if (pop) begin
         nxt_hold = chq.rdData[`UAR_DATA_W-1:0];
         nxt_pend = 1'b1;
         nxt_pendFe = chq.rdData[`UAR_ENTRY_FE];
         nxt_parity = chq.rdData[`UAR_ENTRY_PE];
         if (readyNow) begin
            nxt_overrun = 1'b1;
         end else if (clrSeen_ff) begin
            nxt_overrun = 1'b0;
         end
         // A clear in this same cycle still counts for the next one
         nxt_clrSeen = !clear_char_ready_n;
      end else if (pend_ff && rxFall) begin
         // Setting ready wins over a clear arriving in the same cycle
         nxt_pend = 1'b0;
         nxt_ready = 1'b1;
         nxt_framing = pendFe_ff;
      end
      if (cfg_ff.parityOff) begin
         nxt_parity = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         holdOe_ff <= 1'b0;
         pend_ff <= 1'b0;
         pendFe_ff <= 1'b0;
         ready_ff <= 1'b0;
         clrSeen_ff <= 1'b0;
         overrun_ff <= 1'b0;
         parity_ff <= 1'b0;
         framing_ff <= 1'b0;
      end else begin
         holdOe_ff <= nxt_holdOe;
         pend_ff <= nxt_pend;
         pendFe_ff <= nxt_pendFe;
         ready_ff <= nxt_ready;
         clrSeen_ff <= nxt_clrSeen;
         overrun_ff <= nxt_overrun;
         parity_ff <= nxt_parity;
         framing_ff <= nxt_framing;
      end
   end

   // Holding register keeps its contents through master reset
   always_ff @(posedge clk) begin
      hold_ff <= nxt_hold;
   end

   assign rx_holding_reg = hold_ff;
   assign rx_holding_oe = holdOe_ff;
   assign char_ready_flag = ready_ff;
   assign overrun_flag = overrun_ff;
   assign parity_fault_flag = parity_ff;
   assign framing_fault_flag = framing_ff;

endmodule // uar_rx

//--- verif/uar_rx_checker.sv
// Concurrent checks on the receive block's ports
`timescale 1ns/10ps
module uar_rx_checker (
   input wire logic clk, // System clock
   input wire logic rst, // Master reset
   input wire logic clear_char_ready_n, // Ready clear, low active
   input wire logic char_len_sel_lo, // Length select, low bit
   input wire logic char_len_sel_hi, // Length select, high bit
   input wire logic rx_out_float, // Output float request
   input wire logic [7:0] rx_holding_reg, // Received character
   input wire logic rx_holding_oe, // Holding output drive enable
   input wire logic char_ready_flag, // Character waiting
   input wire logic overrun_flag, // Overrun
   input wire logic parity_fault_flag, // Parity fault
   input wire logic framing_fault_flag // Framing fault
);
   logic [7:0] lenMask;
   // Bits above the selected length; config is held steady across frames
   assign lenMask = 8'hFF << (5 + {char_len_sel_hi, char_len_sel_lo});
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Flags start clear; holding register is not reset so it is not checked
   a_reset_clears_flags: assert property ($fell(rst) |-> !char_ready_flag
      && !overrun_flag && !parity_fault_flag && !framing_fault_flag)
      else $error("flags not clear after reset");
   a_clear_drops_ready: assert property ((!clear_char_ready_n
      ##1 !clear_char_ready_n) |-> !char_ready_flag || $rose(char_ready_flag))
      else $error("ready not cleared");
   a_ready_holds: assert property (char_ready_flag && clear_char_ready_n
      |=> char_ready_flag) else $error("ready dropped by itself");
   a_oe_follows_float: assert property (!$past(rst) |->
      rx_holding_oe == !$past(rx_out_float)) else $error("drive enable wrong");
   a_overrun_needs_ready: assert property ($rose(overrun_flag) |->
      $past(char_ready_flag)) else $error("overrun without ready");
   a_float_freezes_data: assert property (rx_out_float [*3] |->
      $stable(rx_holding_reg)) else $error("data moved while floated");
   a_framing_with_ready: assert property ($changed(framing_fault_flag)
      |-> char_ready_flag) else $error("framing moved without ready");
   a_parity_then_ready: assert property ($changed(parity_fault_flag)
      |-> ##[1:64] char_ready_flag) else $error("ready late after load");
   a_upper_bits_low: assert property ($changed(rx_holding_reg) |->
      (rx_holding_reg & lenMask) == 8'h00) else $error("upper bits set");
endmodule // uar_rx_checker

bind uar_rx uar_rx_checker uar_rx_checker_inst (.clk(clk), .rst(rst),
   .clear_char_ready_n(clear_char_ready_n), .char_len_sel_lo(char_len_sel_lo),
   .char_len_sel_hi(char_len_sel_hi), .rx_out_float(rx_out_float),
   .rx_holding_reg(rx_holding_reg), .rx_holding_oe(rx_holding_oe),
   .char_ready_flag(char_ready_flag), .overrun_flag(overrun_flag),
   .parity_fault_flag(parity_fault_flag),
   .framing_fault_flag(framing_fault_flag));

//--- verif/uar_tx_model.sv
// Behavioural remote serial transmitter driving the receive line
`timescale 1ns/10ps
module uar_tx_model (
   input wire logic clk, // System clock
   input wire logic rxClk, // Receive clock, 16x bit rate
   output logic lineOut // Serial line toward the receiver
);
   // Line idles marking between frames
   initial begin
      lineOut = 1'b1;
   end
   // One bit lasts sixteen receive-clock rises, changed off the clk edge
   task automatic putBit(input logic b);
      @(posedge rxClk);
      @(negedge clk);
      lineOut = b;
      repeat (15) @(posedge rxClk);
   endtask
   // Start, data LSB first, optional parity, stop bits
   task automatic send(input logic [7:0] d, input int nb, input logic parOn,
      input logic parBit, input logic stopBit, input int nStop);
      putBit(1'b0);
      for (int i = 0; i < nb; i++) begin
         putBit(d[i]);
      end
      if (parOn) begin
         putBit(parBit);
      end
      for (int i = 0; i < nStop; i++) begin
         putBit(stopBit);
      end
      // A broken stop is followed by marking so the receiver can rearm
      if (!stopBit) begin
         putBit(1'b1);
      end
   endtask
endmodule // uar_tx_model

//--- verif/uar_rx_tb_top.sv
// Self-checking bench for the UART receive block
`timescale 1ns/10ps
module uar_rx_tb_top;
   logic clk, rst, lineIn, rxClk, clrN, lenLo, lenHi, parOff, evenSel;
   logic stopSel, latchLoad, outFloat, holdOe, ready, ovr, pe, fe, par;
   logic [7:0] holdReg, mask;
   int miscompares = 0;
   int tests_run = 0;

   uar_rx uar_rx_inst (.clk(clk), .rst(rst), .rx_line_in(lineIn),
      .rx_clock_16x(rxClk), .clear_char_ready_n(clrN),
      .char_len_sel_lo(lenLo), .char_len_sel_hi(lenHi),
      .parity_disable_in(parOff), .even_parity_sel(evenSel),
      .stop_count_sel(stopSel), .control_latch_load(latchLoad),
      .rx_out_float(outFloat), .rx_holding_reg(holdReg),
      .rx_holding_oe(holdOe), .char_ready_flag(ready), .overrun_flag(ovr),
      .parity_fault_flag(pe), .framing_fault_flag(fe));
   uar_tx_model uar_tx_model_inst (.clk(clk), .rxClk(rxClk),
      .lineOut(lineIn));

   // System clock, 40 ns period
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Receive clock of four system clocks, each phase two clocks long
   initial begin
      rxClk = 1'b0;
      forever begin
         repeat (2) @(negedge clk);
         rxClk = ~rxClk;
      end
   end
   task automatic tally_and_finish();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e,
      input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait for a character to be reported
   task automatic waitReady();
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      if (ready !== 1'b1) begin
         miscompares++;
         $display("MISMATCH ready expected 1 seen timeout");
         tally_and_finish();
      end
   endtask
   task automatic clearReady();
      @(negedge clk);
      clrN = 1'b0;
      repeat (2) @(negedge clk);
      chk("ready", 8'h00, {7'h00, ready});
      clrN = 1'b1;
   endtask
   // Latch load stays high, so new settings pass straight through
   task automatic setCfg(input logic [1:0] lc, input logic po, input logic ev,
      input logic two);
      @(negedge clk);
      {lenHi, lenLo} = lc;
      parOff = po;
      evenSel = ev;
      stopSel = two;
      repeat (4) @(negedge clk);
   endtask
   // Frame a character for the current setting, parity spoilt on request
   task automatic sendChar(input logic [7:0] d, input logic badPar,
      input logic stopBit);
      mask = 8'hFF >> (2'h3 - {lenHi, lenLo});
      par = ^(d & mask) ^ ~evenSel ^ badPar;
      uar_tx_model_inst.send(d, 5 + {lenHi, lenLo}, !parOff, par, stopBit,
         stopSel ? 2 : 1);
   endtask

   initial begin
      rst = 1'b1;
      clrN = 1'b1;
      latchLoad = 1'b1;
      outFloat = 1'b0;
      {lenHi, lenLo, parOff, evenSel, stopSel} = 5'h00;
      repeat (6) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("flags", 8'h00, {4'h0, ready, ovr, pe, fe});
      // Every length, odd and even parity alternating
      for (int lc = 0; lc < 4; lc++) begin
         setCfg(lc[1:0], 1'b0, lc[0], 1'b0);
         sendChar(8'hA5, 1'b0, 1'b1);
         waitReady();
         chk("data", 8'hA5 & (8'hFF >> (3 - lc)), holdReg);
         chk("parity", 8'h00, {7'h00, pe});
         clearReady();
      end
      setCfg(2'h3, 1'b1, 1'b0, 1'b1);
      sendChar(8'h3C, 1'b1, 1'b1);
      waitReady();
      chk("data", 8'h3C, holdReg);
      chk("parity", 8'h00, {7'h00, pe});
      clearReady();
      setCfg(2'h3, 1'b0, 1'b1, 1'b0);
      sendChar(8'h5A, 1'b1, 1'b1);
      waitReady();
      chk("parity", 8'h01, {7'h00, pe});
      clearReady();
      sendChar(8'h5B, 1'b0, 1'b0);
      waitReady();
      chk("parity", 8'h00, {7'h00, pe});
      chk("framing", 8'h01, {7'h00, fe});
      clearReady();
      sendChar(8'h81, 1'b0, 1'b1);
      waitReady();
      chk("framing", 8'h00, {7'h00, fe});
      clearReady();
      // Back-to-back frames without clearing ready in between
      sendChar(8'h11, 1'b0, 1'b1);
      sendChar(8'h22, 1'b0, 1'b1);
      chk("data", 8'h22, holdReg);
      chk("overrun", 8'h01, {7'h00, ovr});
      clearReady();
      // A clear alone leaves overrun up until the next stop bit
      chk("overrun", 8'h01, {7'h00, ovr});
      sendChar(8'h33, 1'b0, 1'b1);
      waitReady();
      chk("overrun", 8'h00, {7'h00, ovr});
      clearReady();
      // Floated outputs hold the new character back in the queue
      outFloat = 1'b1;
      sendChar(8'h44, 1'b0, 1'b1);
      @(negedge clk);
      chk("drive", 8'h00, {7'h00, holdOe});
      chk("data", 8'h33, holdReg);
      outFloat = 1'b0;
      waitReady();
      chk("data", 8'h44, holdReg);
      chk("drive", 8'h01, {7'h00, holdOe});
      // Mid-run reset with ready up: flags clear, character survives
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk("flags", 8'h00, {4'h0, ready, ovr, pe, fe});
      chk("data", 8'h44, holdReg);
      tally_and_finish();
   end
endmodule // uar_rx_tb_top
